//--- include/ips_regs.svh
`ifndef IPS_REGS_SVH
`define IPS_REGS_SVH
// register byte offsets
`define IPS_OFF_UART_PRIO 12'h000
`define IPS_OFF_CAN_DMA_PRIO 12'h004
`define IPS_OFF_LVL_VEC_STAT 12'h008
`define IPS_OFF_CTRL_ONE 12'h00c
`define IPS_OFF_FLAGS 12'h010
`define IPS_OFF_ENABLES 12'h014
`define IPS_OFF_STAT_LOW 12'h018
`define IPS_OFF_TBLOCK 12'h01c
// priority field positions
`define IPS_SER2_LSB 8
`define IPS_SER1_LSB 4
`define IPS_CAN2_LSB 12
`define IPS_CAN1_LSB 8
`define IPS_CH7_LSB 4
`define IPS_CH6_LSB 0
// implemented bits of the priority registers
`define IPS_UART_MASK 16'h0770
`define IPS_CAN_DMA_MASK 16'h7777
// reset values: every priority field at level 4
`define IPS_PRIO_RST 3'h4
`define IPS_UART_RST 16'h0440
`define IPS_CAN_DMA_RST 16'h4444
// status register fields
`define IPS_STAT_LVL_LSB 8
// control register one
`define IPS_NEST_DIS_BIT 15
`define IPS_CTRL_MASK 16'h800f
// status low byte: level bits 3..1, bit 0 mirrors trap level
`define IPS_STAT_LOW_LVL_LSB 1
`define IPS_USER_MAX 4'h7
// trap levels and vector indices
`define IPS_TRAP_LVL0 4'hb
`define IPS_TRAP_LVL1 4'hc
`define IPS_TRAP_LVL2 4'hd
`define IPS_TRAP_LVL3 4'he
`define IPS_TRAP_VEC0 7'h01
`define IPS_TRAP_VEC1 7'h02
`define IPS_TRAP_VEC2 7'h03
`define IPS_TRAP_VEC3 7'h04
// user source vector indices (vector number minus eight)
`define IPS_VEC_SER1 7'h41
`define IPS_VEC_SER2 7'h42
`define IPS_VEC_CAN1 7'h46
`define IPS_VEC_CAN2 7'h47
`define IPS_VEC_CH6 7'h3d
`define IPS_VEC_CH7 7'h3e
// counts
`define IPS_NUM_USER 6
`define IPS_NUM_SRC 10
`define IPS_STACK_DEPTH 16
`endif

//--- include/ips_pkg.sv
package ips_pkg;
	typedef logic [3:0] ips_level_t;
	typedef logic [6:0] ips_vec_t;
	typedef logic [15:0] ips_word_t;
endpackage : ips_pkg

//--- core/ips_unit.sv
// What this block does
// - each priority field is 3 bits, 7 down to 1 are levels and 0 disables the source.
// - the serial error register holds port 2 in bits 10-8 and port 1 in bits 6-4, others zero.
// - the transmit/transfer register holds CAN 2 in bits 14-12 and CAN 1 in bits 10-8, bits 15 and 11 zero.
// - the same register holds channel 7 in bits 6-4 and channel 6 in bits 2-0, bits 7 and 3 zero.
// - unimplemented bits read zero and ignore writes.
// - every priority field resets to level 4.
// - status bits 11-8 show the new cpu level 0..15, bits 15-12 zero.
// - status bits 6-0 show the pending vector minus eight, bit 7 zero.
// - with nesting disable set no user interrupt pre-empts a running service.
// - a user source requests only when enabled, flagged and at a nonzero priority.
// - return from interrupt restores the previous cpu level saved at entry; a return in the same cycle as an acknowledge is ignored.
// - a cpu level of 7 set by or-ing 0x0e into the status low byte masks all user sources.
// - traps at levels 11 to 14 are masked only by a cpu level at or above their own, which only a taken trap sets.
// - the timed block holds off levels 1-6 for a set count while level 7 still interrupts.
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ns
`include "ips_regs.svh"
module ips_unit
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [5:0] src_event,
	input wire logic [3:0] trap_event,
	input wire logic cpu_ack,
	input wire logic cpu_return,
	output logic int_req,
	output logic [6:0] int_vector,
	output logic [3:0] int_level,
	output logic [3:0] cpu_level
);

	////////////////////////////////////////////////////////////////////////////
	// state
	ips_pkg::ips_word_t uart_reg, uart_next;
	ips_pkg::ips_word_t can_reg, can_next;
	ips_pkg::ips_word_t ctrl_reg, ctrl_next;
	logic [5:0] flag_reg, flag_next;
	logic [5:0] enable_reg, enable_next;
	ips_pkg::ips_word_t tblock_reg, tblock_next;
	ips_pkg::ips_level_t level_reg, level_next;
	// saved levels of nested services; levels only rise, so sixteen entries never wrap
	ips_pkg::ips_level_t stack_reg [`IPS_STACK_DEPTH];
	ips_pkg::ips_level_t stack_next [`IPS_STACK_DEPTH];
	logic [4:0] depth_reg, depth_next;
	logic req_reg, req_next;
	ips_pkg::ips_vec_t vec_reg, vec_next;
	ips_pkg::ips_level_t plvl_reg, plvl_next;
	logic [31:0] rdata_reg, rdata_next;
	logic ready_reg, ready_next;
	logic err_reg, err_next;

	////////////////////////////////////////////////////////////////////////////
	// source table
	ips_pkg::ips_level_t src_lvl [`IPS_NUM_SRC];
	ips_pkg::ips_vec_t src_vec [`IPS_NUM_SRC];
	logic [`IPS_NUM_SRC-1:0] src_raw;
	logic [`IPS_NUM_SRC-1:0] src_ok;

	// entries 0-5 are user sources in event bit order, 6-9 are the traps
	// user levels come straight from the 3-bit fields
	assign src_lvl[0] = {1'b0, uart_reg[`IPS_SER1_LSB +: 3]};
	assign src_lvl[1] = {1'b0, uart_reg[`IPS_SER2_LSB +: 3]};
	assign src_lvl[2] = {1'b0, can_reg[`IPS_CAN1_LSB +: 3]};
	assign src_lvl[3] = {1'b0, can_reg[`IPS_CAN2_LSB +: 3]};
	assign src_lvl[4] = {1'b0, can_reg[`IPS_CH6_LSB +: 3]};
	assign src_lvl[5] = {1'b0, can_reg[`IPS_CH7_LSB +: 3]};
	assign src_lvl[6] = `IPS_TRAP_LVL0;
	assign src_lvl[7] = `IPS_TRAP_LVL1;
	assign src_lvl[8] = `IPS_TRAP_LVL2;
	assign src_lvl[9] = `IPS_TRAP_LVL3;
	assign src_vec[0] = `IPS_VEC_SER1;
	assign src_vec[1] = `IPS_VEC_SER2;
	assign src_vec[2] = `IPS_VEC_CAN1;
	assign src_vec[3] = `IPS_VEC_CAN2;
	assign src_vec[4] = `IPS_VEC_CH6;
	assign src_vec[5] = `IPS_VEC_CH7;
	assign src_vec[6] = `IPS_TRAP_VEC0;
	assign src_vec[7] = `IPS_TRAP_VEC1;
	assign src_vec[8] = `IPS_TRAP_VEC2;
	assign src_vec[9] = `IPS_TRAP_VEC3;

	// raw request: user needs flag and enable; trap needs its flag only
	assign src_raw[5:0] = flag_reg & enable_reg;
	assign src_raw[9:6] = ctrl_reg[3:0];

	////////////////////////////////////////////////////////////////////////////
	// per-source eligibility
	genvar gi;
	generate
		for (gi = 0; gi < `IPS_NUM_SRC; gi++)
		begin : g_elig
			logic is_user;
			logic nest_block;
			logic timed_block;
			// traps sit above every user level, so the level alone tells them apart
			assign is_user = (src_lvl[gi] <= `IPS_USER_MAX);
			// with nesting disable set, a running service is not pre-empted by user sources
			assign nest_block = is_user && ctrl_reg[`IPS_NEST_DIS_BIT] && (depth_reg != 5'h00);
			// timed block holds off levels below 7 only
			assign timed_block = (tblock_reg != 16'h0000) && (src_lvl[gi] < `IPS_USER_MAX);
			// a zero level never passes, whatever the cpu level
			// strict compare against cpu level; traps exceed any user level
			assign src_ok[gi] = src_raw[gi] && (src_lvl[gi] != 4'h0) && (src_lvl[gi] > level_reg)
				&& !nest_block && !timed_block;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// arbitration: highest level, then lowest vector
	logic any_ok;
	logic offer;
	ips_pkg::ips_level_t best_lvl;
	ips_pkg::ips_vec_t best_vec;
	always_comb
	begin
		any_ok = 1'b0;
		best_lvl = 4'h0;
		best_vec = 7'h00;
		// on a tie the vector compare keeps the lower vector, whatever its place in the table
		for (int i = 0; i < `IPS_NUM_SRC; i++)
		begin
			if (src_ok[i] && (!any_ok || (src_lvl[i] > best_lvl)
				|| ((src_lvl[i] == best_lvl) && (src_vec[i] < best_vec))))
			begin
				any_ok = 1'b1;
				best_lvl = src_lvl[i];
				best_vec = src_vec[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// apb decode
	logic setup_ph;
	logic wr_en;
	logic addr_hit;
	assign setup_ph = psel && !penable;
	// a write lands only at the access edge and never at an unmapped address
	assign wr_en = psel && penable && ready_reg && pwrite && !err_reg;
	always_comb
	begin
		unique case (paddr)
			`IPS_OFF_UART_PRIO, `IPS_OFF_CAN_DMA_PRIO, `IPS_OFF_LVL_VEC_STAT, `IPS_OFF_CTRL_ONE,
			`IPS_OFF_FLAGS, `IPS_OFF_ENABLES, `IPS_OFF_STAT_LOW, `IPS_OFF_TBLOCK: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// next state of registers, level stack and request outputs
	always_comb
	begin
		uart_next = uart_reg;
		can_next = can_reg;
		ctrl_next = ctrl_reg;
		flag_next = flag_reg;
		enable_next = enable_reg;
		tblock_next = tblock_reg;
		level_next = level_reg;
		depth_next = depth_reg;
		for (int i = 0; i < `IPS_STACK_DEPTH; i++)
		begin
			stack_next[i] = stack_reg[i];
		end
		// timed block counts down once per clock
		// a write of zero below ends the block at once
		if (tblock_reg != 16'h0000)
		begin
			tblock_next = tblock_reg - 16'h0001;
		end
		// software writes; flag bits clear on writing one
		if (wr_en)
		begin
			unique case (paddr)
				`IPS_OFF_UART_PRIO: uart_next = pwdata[15:0] & `IPS_UART_MASK;
				`IPS_OFF_CAN_DMA_PRIO: can_next = pwdata[15:0] & `IPS_CAN_DMA_MASK;
				`IPS_OFF_CTRL_ONE:
				begin
					// trap flags clear on a written one, nesting disable takes the written bit
					ctrl_next = (ctrl_reg & 16'h000f & ~pwdata[15:0]) | (pwdata[15:0] & `IPS_CTRL_MASK & 16'h8000);
				end
				`IPS_OFF_FLAGS: flag_next = flag_reg & ~pwdata[5:0];
				`IPS_OFF_ENABLES: enable_next = pwdata[5:0];
				`IPS_OFF_STAT_LOW: level_next = {level_reg[3], pwdata[`IPS_STAT_LOW_LVL_LSB +: 3]};
				`IPS_OFF_TBLOCK: tblock_next = pwdata[15:0];
				default: ;
			endcase
		end
		// events set flags after any clear, so the set wins
		flag_next = flag_next | src_event;
		ctrl_next[3:0] = ctrl_next[3:0] | trap_event;
		// return pops the saved level
		// a return together with an acknowledge is ignored, the entry wins
		if (cpu_return && !cpu_ack && (depth_reg != 5'h00))
		begin
			level_next = stack_reg[depth_reg[3:0] - 4'h1];
			depth_next = depth_reg - 5'h01;
		end
		// acceptance pushes the old level and raises the cpu to the taken level
		if (cpu_ack && req_reg)
		begin
			stack_next[depth_reg[3:0]] = level_reg;
			depth_next = depth_reg + 5'h01;
			level_next = plvl_reg;
		end
		// offer only what stands above the level of the next cycle, so a raised cpu
		// level withdraws the request at the same edge instead of one cycle late
		offer = any_ok && (best_lvl > level_next);
		req_next = offer && !cpu_ack;
		vec_next = offer ? best_vec : 7'h00;
		plvl_next = offer ? best_lvl : 4'h0;
	end

	////////////////////////////////////////////////////////////////////////////
	// next state of the bus answer
	always_comb
	begin
		rdata_next = 32'h0000_0000;
		// read data is caught at setup and stands through the one access cycle
		ready_next = setup_ph;
		err_next = setup_ph && !addr_hit;
		if (setup_ph && !pwrite)
		begin
			unique case (paddr)
				`IPS_OFF_UART_PRIO: rdata_next[15:0] = uart_reg;
				`IPS_OFF_CAN_DMA_PRIO: rdata_next[15:0] = can_reg;
				`IPS_OFF_LVL_VEC_STAT: rdata_next[15:0] = {4'h0, plvl_reg, 1'b0, vec_reg};
				`IPS_OFF_CTRL_ONE: rdata_next[15:0] = ctrl_reg;
				`IPS_OFF_FLAGS: rdata_next[5:0] = flag_reg;
				`IPS_OFF_ENABLES: rdata_next[5:0] = enable_reg;
				`IPS_OFF_STAT_LOW: rdata_next[3:0] = {level_reg[2:0], level_reg[3]};
				`IPS_OFF_TBLOCK: rdata_next[15:0] = tblock_reg;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			uart_reg <= `IPS_UART_RST;
			can_reg <= `IPS_CAN_DMA_RST;
			ctrl_reg <= 16'h0000;
			flag_reg <= 6'h00;
			enable_reg <= 6'h00;
			tblock_reg <= 16'h0000;
			level_reg <= 4'h0;
			depth_reg <= 5'h00;
			for (int i = 0; i < `IPS_STACK_DEPTH; i++)
			begin
				stack_reg[i] <= 4'h0;
			end
			req_reg <= 1'b0;
			vec_reg <= 7'h00;
			plvl_reg <= 4'h0;
			rdata_reg <= 32'h0000_0000;
			ready_reg <= 1'b0;
			err_reg <= 1'b0;
		end
		else
		begin
			uart_reg <= uart_next;
			can_reg <= can_next;
			ctrl_reg <= ctrl_next;
			flag_reg <= flag_next;
			enable_reg <= enable_next;
			tblock_reg <= tblock_next;
			level_reg <= level_next;
			depth_reg <= depth_next;
			for (int i = 0; i < `IPS_STACK_DEPTH; i++)
			begin
				stack_reg[i] <= stack_next[i];
			end
			req_reg <= req_next;
			vec_reg <= vec_next;
			plvl_reg <= plvl_next;
			rdata_reg <= rdata_next;
			ready_reg <= ready_next;
			err_reg <= err_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs straight from flip-flops
	assign prdata = rdata_reg;
	assign pready = ready_reg;
	assign pslverr = err_reg;
	assign int_req = req_reg;
	assign int_vector = vec_reg;
	assign int_level = plvl_reg;
	assign cpu_level = level_reg;

endmodule : ips_unit

//--- verif/ips_unit_asserts.sv
`timescale 1ns/1ns
module ips_unit_asserts
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic cpu_ack,
	input wire logic int_req,
	input wire logic [6:0] int_vector,
	input wire logic [3:0] int_level,
	input wire logic [3:0] cpu_level
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	// read words keep unused bits clear
	chk_uart_unused: assert property (pready && !pwrite && paddr == 12'h000 |-> (prdata & ~32'h770) == '0)
		else $error("serial priority word shows unused bits");
	chk_candma_unused: assert property (pready && !pwrite && paddr == 12'h004 |-> (prdata & ~32'h7777) == '0)
		else $error("transfer priority word shows unused bits");
	chk_status_pad: assert property (pready && !pwrite && paddr == 12'h008 |-> prdata[31:12] == '0 && !prdata[7])
		else $error("status word shows unused bits");
	chk_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("ready is not a single access cycle");
	////////////////////////////////////////////////////////////////
	// request selection and masking
	chk_req_above: assert property (int_req |-> int_level > cpu_level && int_level != 4'h0)
		else $error("request not above the cpu level");
	chk_ack_enter: assert property (cpu_ack && int_req |=> cpu_level == $past(int_level) && !int_req)
		else $error("acknowledge did not raise the cpu level");
	chk_user_masked: assert property (int_req && cpu_level >= 4'h7 |-> int_level >= 4'h8)
		else $error("user source passed a level seven mask");
	chk_trap_vector: assert property (int_req && int_level >= 4'h8 |-> int_vector inside {[7'h01:7'h04]})
		else $error("trap level with a user vector");
	chk_user_vector: assert property (int_req && int_level < 4'h8 |-> int_vector inside {7'h41, 7'h42, 7'h46, 7'h47, 7'h3d, 7'h3e})
		else $error("user level with an unknown vector");
endmodule : ips_unit_asserts

//--- verif/ips_cpu_model.sv
`timescale 1ns/1ns
module ips_cpu_model
#(
	parameter int ACK_WAIT = 2
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic int_req,
	input wire logic ack_on,
	input wire logic ret_go,
	output logic cpu_ack,
	output logic cpu_return
);
	logic [3:0] wait_reg;
	// takes an offered interrupt after a short delay, returns on command
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			wait_reg <= '0;
			cpu_ack <= 1'b0;
			cpu_return <= 1'b0;
		end
		else
		begin
			cpu_ack <= int_req && ack_on && !cpu_ack && wait_reg == 4'(ACK_WAIT);
			wait_reg <= (int_req && ack_on && !cpu_ack) ? wait_reg + 4'h1 : 4'h0;
			cpu_return <= ret_go;
		end
endmodule : ips_cpu_model

//--- verif/ips_unit_tb_top.sv
`timescale 1ns/1ns
module ips_unit_tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic cpu_ack, cpu_return, int_req, ack_on = 0, ret_go = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rdat;
	logic [5:0] src_event = '0;
	logic [3:0] trap_event = '0, int_level, cpu_level;
	logic [6:0] int_vector;
	int fails = 0, n_compared = 0, cyc = 0;
	always #5 pclk = ~pclk;
	ips_unit ips_unit_inst(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.src_event, .trap_event, .cpu_ack, .cpu_return, .int_req, .int_vector, .int_level, .cpu_level);
	ips_cpu_model ips_cpu_model_inst(.pclk, .presetn, .int_req, .ack_on, .ret_go, .cpu_ack, .cpu_return);
	////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic give_verdict();
		$display("compared %0d mismatched %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : bus
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask : rd
	task automatic fire(input logic [5:0] s, input logic [3:0] t);
		@(posedge pclk);
		src_event <= s;
		trap_event <= t;
		@(posedge pclk);
		src_event <= '0;
		trap_event <= '0;
		repeat (3) @(posedge pclk);
	endtask : fire
	// compares request, vector, level and cpu level together
	task automatic see(input logic q, input logic [6:0] v, input logic [3:0] l, input logic [3:0] c);
		repeat (2) @(posedge pclk);
		chk(32'({int_req, int_vector, int_level, cpu_level}), 32'({q, v, l, c}));
	endtask : see
	task automatic take(input logic go_back);
		@(posedge pclk);
		ack_on <= !go_back;
		ret_go <= go_back;
		@(posedge pclk);
		ret_go <= 1'b0;
		repeat (6) @(posedge pclk);
		ack_on <= 1'b0;
	endtask : take
	////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_regs();
		rd(12'h000, 32'h440);
		rd(12'h004, 32'h4444);
		rd(12'h008, 32'h0);
		wr(12'h000, 32'hffffffff);
		rd(12'h000, 32'h770);
		wr(12'h004, 32'hffffffff);
		rd(12'h004, 32'h7777);
		wr(12'h008, 32'hffffffff);
		rd(12'h008, 32'h0);
		bus(1'b1, 12'h020, 32'h1);
		chk(32'(err), 32'h1);
	endtask : t_regs
	task automatic t_event();
		wr(12'h000, 32'h0400);
		wr(12'h014, 32'h0);
		fire(6'h03, 4'h0);
		see(1'b0, 7'h0, 4'h0, 4'h0);
		wr(12'h014, 32'h3f);
		see(1'b1, 7'h42, 4'h4, 4'h0);
		rd(12'h008, 32'h0442);
		take(1'b0);
		see(1'b0, 7'h0, 4'h0, 4'h4);
		take(1'b1);
		see(1'b1, 7'h42, 4'h4, 4'h0);
		wr(12'h010, 32'h2);
		see(1'b0, 7'h0, 4'h0, 4'h0);
	endtask : t_event
	task automatic t_prio();
		wr(12'h000, 32'h0030);
		wr(12'h004, 32'h6056);
		fire(6'h3f, 4'h0);
		see(1'b1, 7'h3d, 4'h6, 4'h0);
		wr(12'h018, 32'he);
		see(1'b0, 7'h0, 4'h0, 4'h7);
		fire(6'h0, 4'h1);
		see(1'b1, 7'h01, 4'hb, 4'h7);
		wr(12'h00c, 32'h1);
		see(1'b0, 7'h0, 4'h0, 4'h7);
		wr(12'h018, 32'h0);
	endtask : t_prio
	task automatic t_block();
		wr(12'h01c, 32'h40);
		see(1'b0, 7'h0, 4'h0, 4'h0);
		wr(12'h004, 32'h6076);
		see(1'b1, 7'h3e, 4'h7, 4'h0);
		wr(12'h004, 32'h6056);
		repeat (70) @(posedge pclk);
		see(1'b1, 7'h3d, 4'h6, 4'h0);
	endtask : t_block
	task automatic t_nest();
		wr(12'h00c, 32'h8000);
		wr(12'h010, 32'h3f);
		fire(6'h01, 4'h0);
		take(1'b0);
		fire(6'h08, 4'h0);
		see(1'b0, 7'h0, 4'h0, 4'h3);
		wr(12'h00c, 32'h0);
		see(1'b1, 7'h47, 4'h6, 4'h3);
		take(1'b1);
		see(1'b1, 7'h47, 4'h6, 4'h0);
	endtask : t_nest
	////////////////////////////////////////////////////////////////
	// hang guard and main sequence
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fails++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_event();
		t_prio();
		t_block();
		t_nest();
		give_verdict();
	end
endmodule : ips_unit_tb_top
bind ips_unit ips_unit_asserts ips_unit_asserts_inst(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
	.pready, .cpu_ack, .int_req, .int_vector, .int_level, .cpu_level);
